/* common/host_port_map.svh */
// Constants for the parallel host port of the serial controller
// Summary of operation
// - Three register-select bits choose the internal register targeted by a host access.
// - Device selected only when both high selects are high and the low select low.
// - Either read strobe asserted puts the addressed register on the data bus.
// - Either write strobe asserted loads host data into the addressed register.
// - Rising edge of the address strobe latches selects and register-select bits.
// - Eight-bit tri-state data bus; bit zero is least significant.
// - Active-low read strobe low drives addressed register contents toward the host.
// - Driver-disable output goes low whenever the host reads the device.
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH
`define DATA_W     8
`define ADDR_W     3
`define REG_COUNT  8
`define REG_RESET  8'h00
`define SYNC_W     3
`define PIN_COUNT  9
`define PIN_ADDR_HI 8
`define PIN_ADDR_LO 6
`define PIN_CS_A   5
`define PIN_CS_B   4
`define PIN_CS_C_N 3
`define PIN_AS_N   2
`define PIN_RD     1
`define PIN_WR     0
`endif

/* common/host_port_pkg.sv */
// Types for the parallel host port
`include "host_port_map.svh"
package host_port_pkg;
   typedef logic [`DATA_W-1:0] data_t;
   typedef logic [`ADDR_W-1:0] addr_t;
   typedef enum logic [1:0] {
      ACC_IDLE  = 2'b00,
      ACC_READ  = 2'b01,
      ACC_WRITE = 2'b10
   } access_t;
endpackage

/* logic/host_port.sv */
// Host bus front end: selects, strobes, address latch and register bank
`timescale 1ns/10ps
`include "host_port_map.svh"
module host_port (
   input  wire logic                clk_in,
   input  wire logic                nrst_in,
   input  wire logic                reg_sel_bit0_in,
   input  wire logic                reg_sel_bit1_in,
   input  wire logic                reg_sel_bit2_in,
   input  wire logic                chip_sel_a_in,
   input  wire logic                chip_sel_b_in,
   input  wire logic                chip_sel_c_n_in,
   input  wire logic                addr_latch_strobe_n_in,
   input  wire logic                read_strobe_high_in,
   input  wire logic                read_strobe_low_n_in,
   input  wire logic                write_strobe_high_in,
   input  wire logic                write_strobe_low_n_in,
   input  wire host_port_pkg::data_t host_data_bus_in,
   output host_port_pkg::data_t     host_data_bus_out,
   output logic                     host_data_bus_oe_n_out,
   output logic                     driver_disable_n_out
);
   import host_port_pkg::*;

   // Pins are asynchronous: three stages, act when the last two agree
   logic [`PIN_COUNT-1:0]  pin_raw;
   logic [`PIN_COUNT-1:0]  s1_q, s2_q, s3_q, clean_q, clean_d;
   data_t                  data_s1_q, data_s2_q;
   assign pin_raw[`PIN_ADDR_HI:`PIN_ADDR_LO] = {reg_sel_bit2_in, reg_sel_bit1_in, reg_sel_bit0_in};
   assign pin_raw[`PIN_CS_A]                 = chip_sel_a_in;
   assign pin_raw[`PIN_CS_B]                 = chip_sel_b_in;
   assign pin_raw[`PIN_CS_C_N]               = chip_sel_c_n_in;
   assign pin_raw[`PIN_AS_N]                 = addr_latch_strobe_n_in;
   // Each strobe pair is merged before the synchroniser, so a pair costs one chain
   assign pin_raw[`PIN_RD]                   = read_strobe_high_in | ~read_strobe_low_n_in;
   assign pin_raw[`PIN_WR]                   = write_strobe_high_in | ~write_strobe_low_n_in;

   genvar g;
   generate
      for (g = 0; g < `PIN_COUNT; g++) begin : g_sync
         assign clean_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : clean_q[g];
      end
   endgenerate

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A level seen in one stage only never reaches the filtered copy
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         clean_q <= '0;
      end else begin
         clean_q <= clean_d;
      end
   end

   // Data needs only two stages: it must be stable long before the strobe is filtered
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         data_s1_q <= `REG_RESET;
         data_s2_q <= `REG_RESET;
      end else begin
         data_s1_q <= host_data_bus_in;
         data_s2_q <= data_s1_q;
      end
   end

   // Decode of cleaned pins
   wire   [`ADDR_W-1:0] addr_pin = clean_q[`PIN_ADDR_HI:`PIN_ADDR_LO];
   wire                 sel_pin  = clean_q[`PIN_CS_A] & clean_q[`PIN_CS_B] & ~clean_q[`PIN_CS_C_N];
   wire                 as_n     = clean_q[`PIN_AS_N];
   wire                 rd_act   = clean_q[`PIN_RD];
   wire                 wr_act   = clean_q[`PIN_WR];

   // Address strobe: transparent while high is not the case; latch on rise, pass while low
   logic                as_prev_q;
   addr_t               addr_hold_q, addr_hold_d;
   logic                sel_hold_q, sel_hold_d;
   wire                 as_rise  = as_n & ~as_prev_q;
   assign addr_hold_d = as_rise ? addr_pin : addr_hold_q;
   assign sel_hold_d  = as_rise ? sel_pin  : sel_hold_q;
   // Strobe tied low makes the port follow its pins directly
   wire   addr_t        addr_eff = as_n ? addr_hold_q : addr_pin;
   wire                 sel_eff  = as_n ? sel_hold_q  : sel_pin;

   // Register bank indexed by the register-select bits
   data_t               regs_q [`REG_COUNT];
   logic                wr_prev_q;
   wire                 wr_fire  = sel_eff & wr_act & ~wr_prev_q;
   wire                 rd_on    = sel_eff & rd_act;
   // Capture data once per strobe; data_cap is the second data stage, with no extra stage added
   data_t               data_cap;
   assign data_cap = data_s2_q;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         as_prev_q   <= 1'b0;
         addr_hold_q <= '0;
         sel_hold_q  <= 1'b0;
      end else begin
         as_prev_q   <= as_n;
         addr_hold_q <= addr_hold_d;
         sel_hold_q  <= sel_hold_d;
      end
   end

   // Write is edge driven: a long strobe loads the register once only
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_prev_q <= 1'b0;
      end else begin
         wr_prev_q <= wr_act;
      end
   end

   generate
      for (g = 0; g < `REG_COUNT; g++) begin : g_regs
         always_ff @(posedge clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
               regs_q[g] <= `REG_RESET;
            end else if (wr_fire && addr_eff == addr_t'(g)) begin
               regs_q[g] <= data_cap;
            end
         end
      end
   endgenerate

   // Read data comes from a flop; bus driven only during a selected read
   data_t               rd_data_q;
   logic                rd_on_q;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_data_q <= `REG_RESET;
      end else begin
         rd_data_q <= regs_q[addr_eff];
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_on_q <= 1'b0;
      end else begin
         rd_on_q <= rd_on;
      end
   end

   assign host_data_bus_out      = rd_data_q;
   assign host_data_bus_oe_n_out = ~rd_on_q;
   assign driver_disable_n_out   = ~rd_on_q;

   bus_idle_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !rd_on_q |-> host_data_bus_oe_n_out) else $error("data bus driven outside read");
   driver_disable_n_read_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      rd_on |=> !driver_disable_n_out) else $error("driver disable not low during read");
   read_data_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (rd_on && !wr_fire) |=> (host_data_bus_out == regs_q[$past(addr_eff)]))
      else $error("read data not addressed register");
   select_dec_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (!as_n && !(clean_q[`PIN_CS_A] && clean_q[`PIN_CS_B] && !clean_q[`PIN_CS_C_N])) |-> !wr_fire)
      else $error("write taken while unselected");
   write_load_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      wr_fire |=> (regs_q[$past(addr_eff)] == $past(data_cap))) else $error("write not loaded");
   addr_latch_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      as_rise |=> (addr_hold_q == $past(addr_pin) && sel_hold_q == $past(sel_pin)))
      else $error("address strobe did not latch");
   addr_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (as_n && as_prev_q) |=> $stable(addr_hold_q)) else $error("latched address moved");
   addr_pass_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !as_n |-> (addr_eff == addr_pin)) else $error("address not transparent");
   low_read_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (sel_eff && rd_act) [*2] |-> !host_data_bus_oe_n_out) else $error("read did not drive bus");

   // Further checks on filtering, decode, write strobe edges, address latch and bus turnaround
   driver_disable_n_match_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      driver_disable_n_out == host_data_bus_oe_n_out)
      else $error("driver disable differs from bus enable");
   read_drive_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      rd_on |=> !host_data_bus_oe_n_out)
      else $error("selected read left bus idle");
   unsel_quiet_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !sel_eff |=> host_data_bus_oe_n_out)
      else $error("bus driven while unselected");
   write_quiet_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !rd_act |=> host_data_bus_oe_n_out)
      else $error("bus driven without read strobe");
   write_once_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      wr_fire |=> !wr_fire)
      else $error("one strobe wrote twice");
   strobe_edge_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (wr_act && wr_prev_q) |-> !wr_fire)
      else $error("write taken without strobe edge");
   write_unsel_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !sel_eff |-> !wr_fire)
      else $error("write while deselected");
   sync_agree_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      ((s2_q ^ s3_q) == '0) |=> (clean_q == $past(s3_q)))
      else $error("filtered pins not updated");
   read_addr_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      rd_on |=> (host_data_bus_out == $past(regs_q[addr_eff])))
      else $error("read from wrong register");
   latch_sel_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (as_n && as_prev_q) |=> $stable(sel_hold_q))
      else $error("latched select moved");
   latch_use_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      as_n |-> (addr_eff == addr_hold_q && sel_eff == sel_hold_q))
      else $error("latched values not used");
   as_prev_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      as_n |=> as_prev_q)
      else $error("strobe history lost");
   sel_pass_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !as_n |-> (sel_eff == sel_pin))
      else $error("select not transparent");
endmodule

/* tb/host_cpu_model.sv */
// Host CPU model that drives the parallel port pins
`timescale 1ns/10ps
module host_cpu_model (
   input  wire logic                 clk_in,
   input  wire logic                 oe_n_in,
   input  wire logic                 driver_disable_n_n_in,
   input  wire host_port_pkg::data_t dev_data_in,
   output logic [2:0]                addr_out,
   output logic [2:0]                cs_out,
   output logic                      as_n_out,
   output logic [3:0]                strb_out,
   output host_port_pkg::data_t      bus_out
);
   import host_port_pkg::*;
   data_t drv;
   // No pull on the bus: between accesses a released bus shows the last byte inverted, never the byte itself
   assign bus_out = oe_n_in ? drv : dev_data_in;
   initial begin
      cs_out = 3'b110;
      as_n_out = 1'b0;
      strb_out = 4'b1010;
      addr_out = 3'h0;
      drv = 8'h00;
   end
   // Strobe held 8 cycles, above the input filter delay; order is rd_h, rd_n, wr_h, wr_n
   task automatic access(input logic wr, input logic lo, input addr_t a, input data_t d,
                         output data_t q, output logic seen);
      seen = 1'b0;
      @(negedge clk_in);
      addr_out = a;
      drv = d;
      strb_out[{wr, lo}] = ~lo;
      repeat (8) begin
         @(negedge clk_in);
         if (!oe_n_in && !driver_disable_n_n_in) begin
            seen = 1'b1;
            q = bus_out;
         end
      end
      strb_out = 4'b1010;
      drv = ~d;
      repeat (8) @(negedge clk_in);
   endtask
endmodule

/* tb/uart_cpu_bus_interface_bench.sv */
// Self-checking bench for the host port
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; $display("mismatch %0t %h %h", $time, a, b); end end
module uart_cpu_bus_interface_bench;
   import host_port_pkg::*;
   logic  clk_in = 1'b0;
   logic  nrst_in = 1'b0;
   int    bad_count = 0;
   int    checked = 0;
   logic [2:0] a;
   logic [2:0] cs;
   logic [3:0] st;
   logic  as_n, oe_n, driver_disable_n_n, seen;
   data_t dout, bus, q;
   always #12.5 clk_in = ~clk_in;
   host_port host_port_i (.clk_in(clk_in), .nrst_in(nrst_in), .reg_sel_bit0_in(a[0]), .reg_sel_bit1_in(a[1]),
      .reg_sel_bit2_in(a[2]), .chip_sel_a_in(cs[2]), .chip_sel_b_in(cs[1]), .chip_sel_c_n_in(cs[0]),
      .addr_latch_strobe_n_in(as_n), .read_strobe_high_in(st[0]), .read_strobe_low_n_in(st[1]),
      .write_strobe_high_in(st[2]), .write_strobe_low_n_in(st[3]), .host_data_bus_in(bus),
      .host_data_bus_out(dout), .host_data_bus_oe_n_out(oe_n), .driver_disable_n_out(driver_disable_n_n));
   host_cpu_model host_cpu_model_i (.clk_in(clk_in), .oe_n_in(oe_n), .driver_disable_n_n_in(driver_disable_n_n), .dev_data_in(dout),
      .addr_out(a), .cs_out(cs), .as_n_out(as_n), .strb_out(st), .bus_out(bus));
   task automatic report_and_stop;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Every address, both strobe kinds, read back through the other kind
   task automatic all_regs;
      for (int i = 0; i < 8; i++)
         host_cpu_model_i.access(1'b1, i[0], addr_t'(i), data_t'(8'h5A + 8'h13 * i), q, seen);
      for (int i = 0; i < 8; i++) begin
         host_cpu_model_i.access(1'b0, ~i[0], addr_t'(i), 8'h00, q, seen);
         `CHK(seen, 1'b1)
         `CHK(q, data_t'(8'h5A + 8'h13 * i))
      end
   endtask
   // One select inactive at a time: writes ignored, bus never driven
   task automatic unselected;
      for (int k = 0; k < 3; k++) begin
         host_cpu_model_i.cs_out = 3'b110 ^ (3'b001 << k);
         host_cpu_model_i.access(1'b1, 1'b0, 3'h3, 8'hFF, q, seen);
         host_cpu_model_i.access(1'b0, 1'b1, 3'h3, 8'h00, q, seen);
         `CHK(seen, 1'b0)
         host_cpu_model_i.cs_out = 3'b110;
      end
      host_cpu_model_i.access(1'b0, 1'b0, 3'h3, 8'h00, q, seen);
      `CHK(q, data_t'(8'h5A + 8'h13 * 3))
   endtask
   // Address latched on the strobe's rise; later pin changes are ignored
   task automatic addr_latch;
      @(negedge clk_in);
      host_cpu_model_i.addr_out = 3'h5;
      repeat (4) @(negedge clk_in);
      host_cpu_model_i.as_n_out = 1'b1;
      repeat (6) @(negedge clk_in);
      host_cpu_model_i.access(1'b1, 1'b1, 3'h2, 8'hC3, q, seen);
      host_cpu_model_i.as_n_out = 1'b0;
      host_cpu_model_i.access(1'b0, 1'b0, 3'h5, 8'h00, q, seen);
      `CHK(q, 8'hC3)
      host_cpu_model_i.access(1'b0, 1'b1, 3'h2, 8'h00, q, seen);
      `CHK(q, data_t'(8'h5A + 8'h13 * 2))
   endtask
   initial begin
      repeat (5) @(negedge clk_in);
      nrst_in = 1'b1;
      all_regs();
      unselected();
      addr_latch();
      report_and_stop();
   end
   initial begin
      #200000;
      bad_count++;
      report_and_stop();
   end
endmodule
